// ### verilog/tfr_pkg.sv
/*
 * Shared constants for the transmit FIFO control and receive parallel side.
 * Assumes one core clock standing in for the clock multiplier output and
 * the recovered bit clock; all other pins arrive from outside that clock.
 */
package tfr_pkg;
	// ----------------------------------------------------------------
	// widths and divide ratios
	// ----------------------------------------------------------------
	localparam int NIBBLE_W = 4;
	localparam int FIFO_DEPTH = 8;
	localparam int PCLK_DIV = 4;
	localparam int AUX_DIV = 16;
	localparam int DIV_W = 4;
	localparam logic [DIV_W-1:0] AUX_LAST = 4'hf;
	localparam logic [1:0] PCLK_LAST = 2'h3;
	localparam logic [1:0] RX_LOAD_PHASE = 2'h1;
	localparam logic [NIBBLE_W-1:0] ZERO_NIBBLE = 4'h0;

	// ----------------------------------------------------------------
	// flush timing, in parallel clock periods then core cycles
	// ----------------------------------------------------------------
	localparam int FLUSH_PCLKS = 9;
	localparam int FLUSH_CYCLES = FLUSH_PCLKS * PCLK_DIV;
	localparam int FLUSH_CNT_W = 6;
	localparam logic [FLUSH_CNT_W-1:0] FLUSH_CNT_LOAD = 6'(FLUSH_CYCLES - 1);

	// ----------------------------------------------------------------
	// bit positions in the pin synchroniser bank
	// ----------------------------------------------------------------
	localparam int S_DIS = 0;
	localparam int S_AUTO = 1;
	localparam int S_FLUSH = 2;
	localparam int S_LOCK = 3;
	localparam int S_LOSS = 4;
	localparam int S_MUTE = 5;
	localparam int S_TXCLK = 6;
	localparam int S_RXD = 7;
	localparam int S_TXD = 8;
	localparam int SYNC_W = 12;

	// flush sequencer states
	typedef enum logic [1:0] {
		TFR_RUN,
		TFR_HOLD,
		TFR_DRAIN
	} tfr_flush_e;
endpackage

// ### verilog/tfr_fifo.sv
/*
 * Small synchronous FIFO in flip-flops with valid/ready on both sides.
 * Assumes one clock, synchronous active-low reset and a synchronous clear.
 */
`timescale 1ns/10ps
module tfr_fifo #(
	parameter int WIDTH = 4,
	parameter int DEPTH = 8
) (
	input wire logic clk,
	input wire logic nrst,
	input wire logic clear,
	input wire logic in_valid,
	output logic in_ready,
	input wire logic [WIDTH-1:0] in_data,
	output logic out_valid,
	input wire logic out_ready,
	output logic [WIDTH-1:0] out_data
);
	localparam int AW = $clog2(DEPTH);

	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW-1:0] wr_ptr;
	logic [AW-1:0] rd_ptr;
	logic [AW:0] count;
	logic do_push;
	logic do_pop;

	// pointer advance with wrap
	function automatic logic [AW-1:0] next_ptr(input logic [AW-1:0] p);
		next_ptr = (p == AW'(DEPTH - 1)) ? '0 : p + 1'b1;
	endfunction

	// honest full and empty
	assign in_ready = (count != (AW + 1)'(DEPTH));
	assign out_valid = (count != '0);
	assign out_data = mem[rd_ptr];
	assign do_push = in_valid && in_ready;
	assign do_pop = out_valid && out_ready;

	// storage write
	always_ff @(posedge clk) begin
		if (do_push && !clear) begin
			mem[wr_ptr] <= in_data;
		end
	end

	// pointers and fill level
	always_ff @(posedge clk) begin
		if (!nrst || clear) begin
			wr_ptr <= '0;
			rd_ptr <= '0;
			count <= '0;
		end else begin
			if (do_push) begin
				wr_ptr <= next_ptr(wr_ptr);
			end
			if (do_pop) begin
				rd_ptr <= next_ptr(rd_ptr);
			end
			count <= count + (AW + 1)'(do_push) - (AW + 1)'(do_pop);
		end
	end

	a_fifo_level: assert property (@(posedge clk) disable iff (!nrst)
		count <= (AW + 1)'(DEPTH))
		else $error("fifo level above depth");
endmodule

// ### verilog/tfr_ctrl.sv
/*
 * Transmit FIFO flush/overflow control, auxiliary clocks, lock flag and
 * receive parallel output with mute and force-to-zero.
 * Assumes clk is the multiplier output, all pins are asynchronous to it.
 */
// Summary of operation
// - aux transmit clock is the multiplier output divided by sixteen, both rates.
// - aux clock runs while disable is low, stops low while disable is high.
// - lock flag follows the multiplier lock state.
// - spill flag is high while a transmit FIFO overflow stands.
// - after manual flush falls, flush finishes in nine parallel clocks.
// - FIFO held in reset while manual flush is high.
// - with auto flush enabled an overflow starts a flush by itself.
// - all four receive data bits change together on receive clock rise.
// - receive nibble is built MSB first, first bit on bit 3.
// - receive parallel clock is the bit clock divided by four.
// - force-zero input clears receive data outputs asynchronously.
// - transmit nibble sampled on input clock rise, sent MSB first.
// - with mute enabled, loss of signal forces receive data to zero.
`timescale 1ns/10ps
module tfr_ctrl
	import tfr_pkg::*;
(
	input wire logic clk,
	input wire logic nrst,
	input wire logic tx_parallel_clock_in,
	input wire logic [NIBBLE_W-1:0] tx_parallel_data_in,
	input wire logic aux_clock_disable,
	input wire logic auto_flush_enable,
	input wire logic tx_fifo_flush_req,
	input wire logic clock_multiplier_locked,
	input wire logic rx_serial_in,
	input wire logic signal_loss_condition,
	input wire logic signal_loss_mute,
	input wire logic rx_data_force_zero,
	output logic aux_tx_clock_out,
	output logic tx_parallel_clock_out,
	output logic multiplier_lock_flag,
	output logic tx_fifo_spill,
	output logic tx_fifo_ready,
	output logic tx_serial_out,
	output logic [NIBBLE_W-1:0] rx_parallel_data,
	output logic rx_parallel_clock_out
);
	// ----------------------------------------------------------------
	// pin synchronisers
	// ----------------------------------------------------------------
	logic [SYNC_W-1:0] meta;
	logic [SYNC_W-1:0] sync;
	logic txclk_last;

	// two flops on every pin except force-zero, then one more for edge detect
	always_ff @(posedge clk) begin
		if (!nrst) begin
			meta <= '0;
			sync <= '0;
			txclk_last <= 1'b0;
		end else begin
			meta <= {tx_parallel_data_in, rx_serial_in, tx_parallel_clock_in,
				signal_loss_mute, signal_loss_condition, clock_multiplier_locked,
				tx_fifo_flush_req, auto_flush_enable, aux_clock_disable};
			sync <= meta;
			txclk_last <= sync[S_TXCLK];
		end
	end

	// synchronised pin levels
	wire logic dis_s = sync[S_DIS];
	wire logic auto_s = sync[S_AUTO];
	wire logic flush_s = sync[S_FLUSH];
	wire logic lock_s = sync[S_LOCK];
	wire logic mute_on = sync[S_MUTE] && sync[S_LOSS];
	wire logic [NIBBLE_W-1:0] txd_s = sync[S_TXD +: NIBBLE_W];

	// ----------------------------------------------------------------
	// transmit clock outputs
	// ----------------------------------------------------------------
	logic [DIV_W-1:0] div_cnt;
	logic aux_run;
	logic pclk_tick;
	// free-running divider from the multiplier output
	always_ff @(posedge clk) begin
		if (!nrst) begin
			div_cnt <= '0;
		end else begin
			div_cnt <= div_cnt + 1'b1;
		end
	end

	// enable changes only in the low half, so the gate never glitches
	always_ff @(posedge clk) begin
		if (!nrst) begin
			aux_run <= 1'b0;
		end else if (div_cnt == AUX_LAST) begin
			aux_run <= !dis_s;
		end
	end

	assign aux_tx_clock_out = div_cnt[DIV_W-1] && aux_run;
	assign tx_parallel_clock_out = div_cnt[1];
	assign pclk_tick = (div_cnt[1:0] == PCLK_LAST);

	// lock indication
	always_ff @(posedge clk) begin
		if (!nrst) begin
			multiplier_lock_flag <= 1'b0;
		end else begin
			multiplier_lock_flag <= lock_s;
		end
	end

	// ----------------------------------------------------------------
	// transmit FIFO and flush sequencer
	// ----------------------------------------------------------------
	tfr_flush_e state;
	tfr_flush_e next_state;
	logic [FLUSH_CNT_W-1:0] flush_cnt;
	logic fifo_valid;
	logic [NIBBLE_W-1:0] fifo_data;
	// sample on rising edge of the framer's clock
	wire logic push = sync[S_TXCLK] && !txclk_last && (state == TFR_RUN);
	wire logic overflow_evt = push && !tx_fifo_ready;
	wire logic fifo_clear = (state != TFR_RUN);
	wire logic flush_done = (state == TFR_DRAIN) && (flush_cnt == '0) && !flush_s;
	wire logic fifo_pop = pclk_tick && lock_s && (state == TFR_RUN);

	tfr_fifo #(
		.WIDTH(NIBBLE_W),
		.DEPTH(FIFO_DEPTH)
	) u_fifo (
		.clk(clk),
		.nrst(nrst),
		.clear(fifo_clear),
		.in_valid(push),
		.in_ready(tx_fifo_ready),
		.in_data(txd_s),
		.out_valid(fifo_valid),
		.out_ready(fifo_pop),
		.out_data(fifo_data)
	);

	// flush state choice
	always_comb begin
		next_state = state;
		unique case (state)
			TFR_RUN: begin
				if (flush_s) begin
					next_state = TFR_HOLD;
				end else if (overflow_evt && auto_s) begin
					next_state = TFR_DRAIN;
				end
			end
			TFR_HOLD: begin
				if (!flush_s) begin
					next_state = TFR_DRAIN;
				end
			end
			TFR_DRAIN: begin
				if (flush_s) begin
					next_state = TFR_HOLD;
				end else if (flush_cnt == '0) begin
					next_state = TFR_RUN;
				end
			end
		endcase
	end

	// flush state and drain counter
	always_ff @(posedge clk) begin
		if (!nrst) begin
			state <= TFR_RUN;
			flush_cnt <= '0;
		end else begin
			state <= next_state;
			if (next_state == TFR_DRAIN && state != TFR_DRAIN) begin
				flush_cnt <= FLUSH_CNT_LOAD;
			end else if (state == TFR_DRAIN && flush_cnt != '0) begin
				flush_cnt <= flush_cnt - 1'b1;
			end
		end
	end

	// spill flag, a new overflow wins over the clearing flush
	always_ff @(posedge clk) begin
		if (!nrst) begin
			tx_fifo_spill <= 1'b0;
		end else if (overflow_evt) begin
			tx_fifo_spill <= 1'b1;
		end else if (flush_done) begin
			tx_fifo_spill <= 1'b0;
		end
	end

	// ----------------------------------------------------------------
	// transmit serialiser
	// ----------------------------------------------------------------
	logic [NIBBLE_W-1:0] tx_shift;
	// load a nibble per parallel clock, shift out MSB first
	always_ff @(posedge clk) begin
		if (!nrst) begin
			tx_shift <= ZERO_NIBBLE;
		end else if (pclk_tick) begin
			tx_shift <= (fifo_pop && fifo_valid) ? fifo_data : ZERO_NIBBLE;
		end else begin
			tx_shift <= {tx_shift[NIBBLE_W-2:0], 1'b0};
		end
	end

	assign tx_serial_out = tx_shift[NIBBLE_W-1];

	// ----------------------------------------------------------------
	// receive deserialiser
	// ----------------------------------------------------------------
	logic [1:0] rx_cnt;
	logic [NIBBLE_W-2:0] rx_shift;
	logic [NIBBLE_W-1:0] rx_data;
	// load point, where the receive clock is about to rise
	wire logic rx_load = (rx_cnt == RX_LOAD_PHASE);
	// bit counter, its top bit is the receive parallel clock
	always_ff @(posedge clk) begin
		if (!nrst) begin
			rx_cnt <= '0;
		end else begin
			rx_cnt <= rx_cnt + 1'b1;
		end
	end

	// oldest bit ends up on bit 3
	always_ff @(posedge clk) begin
		if (!nrst) begin
			rx_shift <= '0;
		end else begin
			rx_shift <= {rx_shift[NIBBLE_W-3:0], sync[S_RXD]};
		end
	end

	// whole nibble loaded at the receive clock rising edge
	always_ff @(posedge clk) begin
		if (!nrst) begin
			rx_data <= ZERO_NIBBLE;
		end else if (rx_load) begin
			rx_data <= mute_on ? ZERO_NIBBLE : {rx_shift, sync[S_RXD]};
		end
	end

	assign rx_parallel_clock_out = rx_cnt[1];
	// force-zero is a plain gate, no clock in its path
	assign rx_parallel_data = rx_data & {NIBBLE_W{!rx_data_force_zero}};

	// ----------------------------------------------------------------
	// assertions
	// ----------------------------------------------------------------
	sequence s_flush_release;
		$fell(flush_s) && state == TFR_HOLD;
	endsequence
	sequence s_drain_then_run;
		(state == TFR_DRAIN) [*8] ##28 (state == TFR_DRAIN) ##1 (state == TFR_RUN);
	endsequence
	a_aux_divide: assert property (@(posedge clk) disable iff (!nrst)
		$rose(aux_tx_clock_out) |-> ##16 $rose(aux_tx_clock_out) || !aux_run)
		else $error("aux clock period not sixteen cycles");
	a_aux_stop: assert property (@(posedge clk) disable iff (!nrst)
		$rose(dis_s) ##1 dis_s [*8] ##1 dis_s [*8] |-> !aux_tx_clock_out)
		else $error("aux clock still running while disabled");
	a_lock_follow: assert property (@(posedge clk) disable iff (!nrst)
		##1 multiplier_lock_flag == $past(sync[S_LOCK]))
		else $error("lock flag does not follow multiplier lock");
	a_spill_set: assert property (@(posedge clk) disable iff (!nrst)
		push && !tx_fifo_ready |=> tx_fifo_spill)
		else $error("overflow did not raise spill flag");
	a_flush_time: assert property (@(posedge clk) disable iff (!nrst)
		s_flush_release |-> ##1 s_drain_then_run or ##[1:36] flush_s)
		else $error("flush not complete in nine parallel clocks");
	a_fifo_held: assert property (@(posedge clk) disable iff (!nrst)
		flush_s ##1 flush_s |=> !fifo_valid)
		else $error("fifo not held empty during manual flush");
	a_auto_flush: assert property (@(posedge clk) disable iff (!nrst)
		overflow_evt && !flush_s |=> state == ($past(auto_s) ? TFR_DRAIN : TFR_RUN))
		else $error("auto flush choice wrong");
	a_rx_together: assert property (@(posedge clk) disable iff (!nrst)
		rx_data != $past(rx_data) |-> $rose(rx_parallel_clock_out))
		else $error("receive data changed off clock edge");
	a_rx_msb_first: assert property (@(posedge clk) disable iff (!nrst)
		rx_load && !mute_on ##1 1 |-> rx_data[NIBBLE_W-1] == $past(sync[S_RXD], 4))
		else $error("first received bit not on bit 3");
	a_rx_force_zero: assert property (@(posedge clk) disable iff (!nrst)
		rx_data_force_zero |-> rx_parallel_data == ZERO_NIBBLE)
		else $error("force-zero did not clear receive data");
	a_rx_mute: assert property (@(posedge clk) disable iff (!nrst)
		rx_load && mute_on |=> rx_data == ZERO_NIBBLE)
		else $error("loss mute did not clear receive data");
	a_spill_clear: assert property (@(posedge clk) disable iff (!nrst)
		flush_done |=> !tx_fifo_spill)
		else $error("spill flag stuck after flush");
endmodule

// ### tb/tfr_framer.sv
/*
 * Framer model that drives the transmit parallel pins of the block.
 * Assumes clk is the core clock and nrst its synchronous active-low reset.
 */
`timescale 1ns/10ps
module tfr_framer
	import tfr_pkg::*;
(
	input wire logic clk,
	input wire logic nrst,
	input wire logic en,
	input wire logic slow,
	input wire logic [NIBBLE_W-1:0] nib,
	output logic tclk,
	output logic [NIBBLE_W-1:0] tdata,
	output logic sent
);
	logic [2:0] ph;
	logic act;

	// one pin clock per nibble, all four bits set together
	always_ff @(posedge clk) begin
		sent <= 1'b0;
		if (!nrst) begin
			ph <= 3'h0;
			act <= 1'b0;
			tclk <= 1'b0;
			tdata <= 4'h0;
		end else if (!act) begin
			tdata <= en ? nib : ~tdata; // idle bus wanders, clock stands low
			act <= en;
			ph <= 3'h0;
		end else begin
			ph <= ph + 3'h1;
			if (ph == (slow ? 3'h3 : 3'h1)) begin
				tclk <= 1'b1; // data already stable before the rise
				sent <= 1'b1;
			end
			if (ph == (slow ? 3'h7 : 3'h3)) begin
				tclk <= 1'b0;
				tdata <= en ? nib : ~tdata;
				act <= en;
				ph <= 3'h0;
			end
		end
	end
endmodule

// ### tb/tb_tx_fifo_and_rx_parallel_ctrl.sv
/*
 * Self-checking bench for tfr_ctrl with a framer model on the transmit pins.
 * Assumes a 25 MHz core clock and synchronous active-low reset.
 */
`timescale 1ns/10ps
module tb_tx_fifo_and_rx_parallel_ctrl
	import tfr_pkg::*;
;
	logic clk, nrst, en, slow, dis, auto, req, lock, rxs, loss, mute, fz;
	logic tclk, sent, aux, pco, lk, spill, rdy, txs, rco;
	logic [NIBBLE_W-1:0] nib, tdata, rxd, sh;
	logic [NIBBLE_W-1:0] q[$];
	int err_count = 0;
	int total_checks = 0;
	int seed = 9;
	int sends = 0;
	int col = 0;
	bit watch = 0;

	tfr_framer fr (.clk(clk), .nrst(nrst), .en(en), .slow(slow), .nib(nib),
		.tclk(tclk), .tdata(tdata), .sent(sent));
	tfr_ctrl dut (.clk(clk), .nrst(nrst), .tx_parallel_clock_in(tclk),
		.tx_parallel_data_in(tdata), .aux_clock_disable(dis), .auto_flush_enable(auto),
		.tx_fifo_flush_req(req), .clock_multiplier_locked(lock), .rx_serial_in(rxs),
		.signal_loss_condition(loss), .signal_loss_mute(mute), .rx_data_force_zero(fz),
		.aux_tx_clock_out(aux), .tx_parallel_clock_out(pco), .multiplier_lock_flag(lk),
		.tx_fifo_spill(spill), .tx_fifo_ready(rdy), .tx_serial_out(txs),
		.rx_parallel_data(rxd), .rx_parallel_clock_out(rco));

	// ----------------------------------------------------------------
	// clock, helpers
	// ----------------------------------------------------------------
	initial begin
		clk = 1'b0;
		forever #20 clk = ~clk;
	end

	task automatic check(input logic [7:0] seen, input logic [7:0] exp);
		total_checks++;
		if (seen !== exp) begin
			err_count++;
			$display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask

	task automatic report_and_stop();
		$display("checks=%0d errors=%0d", total_checks, err_count);
		if (err_count == 0 && total_checks > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask

	task automatic tick(input int n);
		repeat (n) @(posedge clk);
	endtask

	// bounded wait for the spill flag to reach a level
	task automatic wait_spill(input logic v, input int lim);
		int i;
		for (i = 0; i < lim && spill !== v; i++) begin
			@(posedge clk);
		end
		if (spill !== v) begin
			err_count++;
			report_and_stop();
		end
	endtask

	// rising edges and high cycles of one clock output over 64 cycles
	task automatic meas(input int w, input int er, input int eh);
		logic p;
		logic v;
		int r;
		int h;
		r = 0;
		h = 0;
		@(posedge clk);
		p = (w == 0) ? aux : (w == 1) ? pco : rco;
		repeat (64) begin
			@(posedge clk);
			v = (w == 0) ? aux : (w == 1) ? pco : rco;
			r += int'(v & ~p);
			h += int'(v);
			p = v;
		end
		check(r[7:0], er[7:0]);
		check(h[7:0], eh[7:0]);
	endtask

	// ----------------------------------------------------------------
	// stimulus noting and serial monitor
	// ----------------------------------------------------------------
	always @(posedge clk) begin
		nib <= {1'b1, 3'($random(seed))};
		if (sent) sends++;
		if (sent && watch) q.push_back(tdata);
		if (col > 0) begin
			sh = {sh[2:0], txs};
			col++;
		end else if (watch && txs === 1'b1) begin
			sh = 4'h1;
			col = 1;
		end
		if (col == 4) begin
			col = 0;
			check({4'h0, sh}, {4'h0, (q.size() > 0) ? q.pop_front() : 4'h0});
		end
	end

	initial begin
		tick(40000);
		err_count++;
		report_and_stop();
	end

	// ----------------------------------------------------------------
	// main sequence
	// ----------------------------------------------------------------
	initial begin
		{nrst, en, slow, dis, auto, lock, rxs, loss, mute, fz} = 10'h0;
		nib = 4'h8;
		req = 1'b1;
		tick(20);
		nrst <= 1'b1;
		tick(12); // power-up manual flush over three parallel clocks
		req <= 1'b0;
		tick(50);
		check(spill, 0);
		meas(0, 4, 32);
		meas(1, 16, 32);
		meas(2, 16, 32);
		dis <= 1'b1;
		tick(24);
		meas(0, 0, 0);
		dis <= 1'b0;
		tick(24);
		meas(0, 4, 32);
		lock <= 1'b1;
		tick(5);
		check(lk, 1);
		lock <= 1'b0;
		tick(5);
		check(lk, 0);
		// overflow without auto flush, drain stalled by lost lock
		slow <= 1'b1;
		sends = 0;
		en <= 1'b1;
		wait_spill(1'b1, 200);
		check(sends[7:0], 9);
		check(rdy, 0);
		en <= 1'b0;
		tick(60);
		check(spill, 1);
		check(rdy, 0);
		// manual flush with pushes offered during it
		req <= 1'b1;
		en <= 1'b1;
		tick(20);
		check(rdy, 1);
		en <= 1'b0;
		tick(12);
		req <= 1'b0;
		tick(16);
		req <= 1'b1; // request again in mid-drain restarts the hold
		tick(12);
		check(spill, 1);
		req <= 1'b0;
		tick(32);
		check(spill, 1);
		wait_spill(1'b0, 14);
		check(rdy, 1);
		// automatic flush on overflow
		auto <= 1'b1;
		en <= 1'b1;
		wait_spill(1'b1, 200);
		en <= 1'b0;
		wait_spill(1'b0, 50);
		check(rdy, 1);
		auto <= 1'b0;
		// serial transmit, nothing left over from the flushes
		lock <= 1'b1;
		slow <= 1'b0;
		watch <= 1'b1;
		en <= 1'b1;
		tick(48);
		en <= 1'b0;
		tick(60);
		check(q.size(), 0);
		// receive side
		rxs <= 1'b1;
		tick(16);
		check(rxd, 8'h0f);
		rxs <= 1'b0;
		repeat (12) begin
			@(posedge clk);
			check(rxd inside {4'hf, 4'he, 4'hc, 4'h8, 4'h0}, 1);
		end
		rxs <= 1'b1;
		tick(16);
		fz <= 1'b1;
		#2;
		check(rxd, 0);
		@(posedge clk);
		fz <= 1'b0;
		#2;
		check(rxd, 8'h0f);
		loss <= 1'b1;
		tick(10);
		check(rxd, 8'h0f);
		mute <= 1'b1;
		tick(10);
		check(rxd, 0);
		loss <= 1'b0;
		tick(10);
		check(rxd, 8'h0f);
		report_and_stop();
	end
endmodule
